// ==== pkg/pbus_defines.svh ====
`ifndef PBUS_DEFINES_SVH
`define PBUS_DEFINES_SVH

// reply encodings, high bit first
`define PBUS_REPLY_RSVD       2'h0
`define PBUS_REPLY_WAIT       2'h1
`define PBUS_REPLY_SUCCESS    2'h2
`define PBUS_REPLY_FAULT      2'h3

// access size encodings on the core request port
`define PBUS_SIZE_BYTE        2'h0
`define PBUS_SIZE_HALF        2'h1
`define PBUS_SIZE_WORD        2'h2

// wishbone register byte offsets
`define PBUS_REG_CTRL         4'h0
`define PBUS_REG_STATUS       4'h4
`define PBUS_REG_FAULTS       4'h8

// field positions
`define PBUS_CTRL_RSV_FAULT   0
`define PBUS_STAT_IRSV        0
`define PBUS_STAT_DRSV        1

// reset values
`define PBUS_CTRL_RESET       8'h00
`define PBUS_STAT_RESET       2'h0
`define PBUS_RESET_VECTOR     30'h00000000

`endif

// ==== pkg/pbus_pkg.sv ====
package pbus_pkg;
  `include "pbus_defines.svh"

  // phase type currently presented on the instruction bus
  typedef enum logic [2:0]
  {
    IST_BOOT  = 3'b001,
    IST_FETCH = 3'b010,
    IST_NULL  = 3'b100
  } ifetch_state_t;

  typedef enum logic [1:0]
  {
    RK_SUCCESS = 2'h0,
    RK_WAIT    = 2'h1,
    RK_FAULT   = 2'h2
  } reply_kind_t;

  typedef enum logic [1:0]
  {
    SZ_BYTE = `PBUS_SIZE_BYTE,
    SZ_HALF = `PBUS_SIZE_HALF,
    SZ_WORD = `PBUS_SIZE_WORD
  } access_size_t;
endpackage

// ==== logic/pipelined_processor_bus_port.sv ====
// Local design decisions: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
`include "pbus_defines.svh"

// Operation
// - everything launched and sampled on the single processor clock
// - full words on both buses; bytes and half-words only on data bus
// - address buses carry word address only; low two bits implied zero
// - slave may return full word; processor extracts requested bytes itself
// - each bus carries a supervisor/user space select per transaction
// - processor drives addresses, enables, strobe, and data except on reads
// - a new address phase may issue every cycle before prior reply
// - idle cycles are null transactions: lines driven, enables or strobe negated
// - replies to null transactions are ignored on both buses
// - byte enable n qualifies data bits 8n+7 down to 8n
// - data read/write output is high for reads, low for writes
// - lock output holds data bus locked; instruction bus has none
// - instruction side fetches every cycle except three null cases
// - during stalls the next needed instruction address is repeated
// - replies to stall repeats are ignored until the pipeline advances
// - exactly one null fetch after reset with strobe undriven
// - return with invalid pointer issues one null instruction transaction
// - access after a taken instruction fault exception is a null transaction
// - on wait reply, ignore code lines and keep presenting next address
// - fault reply marks the instruction invalid; exception only if executed
module pipelined_processor_bus_port #(
  parameter int WB_ADDR_W = 8
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // wishbone classic slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [WB_ADDR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  // core side, instruction unit
  input  wire logic                   supervisor_i,
  input  wire logic                   stall_i,
  input  wire logic                   redirect_i,
  input  wire logic                   rte_invalid_i,
  input  wire logic                   exc_taken_i,
  input  wire logic [29:0]            target_i,
  output logic                        instr_valid_o,
  output logic      [31:0]            instr_word_o,
  output logic                        instr_fault_o,
  // core side, data unit
  input  wire logic                   dreq_valid_i,
  output logic                        dreq_ready_o,
  input  wire logic                   dreq_write_i,
  input  wire logic                   dreq_signed_i,
  input  wire pbus_pkg::access_size_t dreq_size_i,
  input  wire logic [31:0]            dreq_addr_i,
  input  wire logic [31:0]            dreq_wdata_i,
  input  wire logic                   data_bus_lock_i,
  output logic                        drsp_valid_o,
  output logic      [31:0]            drsp_data_o,
  output logic                        drsp_fault_o,
  // instruction bus
  output logic      [29:0]            instr_word_address_o,
  output logic                        instr_space_select_o,
  output logic                        instr_fetch_strobe_o,
  output logic                        instr_fetch_strobe_oe_o,
  input  wire logic [31:0]            instr_word_lines_i,
  input  wire logic [1:0]             instr_side_reply_i,
  // data bus
  output logic      [29:0]            data_word_address_o,
  output logic                        data_space_select_o,
  output logic      [3:0]             byte_lane_enables_o,
  output logic                        data_read_not_write_o,
  output logic                        data_bus_lock_o,
  output logic      [31:0]            data_word_lines_o,
  output logic                        data_word_lines_oe_o,
  input  wire logic [31:0]            data_word_lines_i,
  input  wire logic [1:0]             data_side_reply_i
);
  import pbus_pkg::*;

  if (WB_ADDR_W < 5)
  begin : g_check
    $error("WB_ADDR_W must be at least 5");
  end

  // reserved code 00 maps to fault or wait as software selects
  function automatic reply_kind_t reply_kind(input logic [1:0] raw, input logic rsv_fault);
    reply_kind_t k;
    k = RK_SUCCESS;
    case (raw)
      `PBUS_REPLY_SUCCESS: k = RK_SUCCESS;
      `PBUS_REPLY_WAIT:    k = RK_WAIT;
      `PBUS_REPLY_FAULT:   k = RK_FAULT;
      default:             k = rsv_fault ? RK_FAULT : RK_WAIT;
    endcase
    return k;
  endfunction

  function automatic logic [3:0] lane_mask(input access_size_t sz, input logic [1:0] off);
    logic [3:0] m;
    m = 4'hf;
    case (sz)
      SZ_BYTE: m = 4'h1 << off;
      SZ_HALF: m = off[1] ? 4'hc : 4'h3;
      default: m = 4'hf;
    endcase
    return m;
  endfunction

  // replicate narrow data so any lane the slave picks is right
  function automatic logic [31:0] spread(input access_size_t sz, input logic [31:0] d);
    logic [31:0] r;
    r = d;
    case (sz)
      SZ_BYTE: r = {4{d[7:0]}};
      SZ_HALF: r = {2{d[15:0]}};
      default: r = d;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] extract(input logic [31:0] w, input logic [1:0] off,
                                          input access_size_t sz, input logic sgn);
    logic [31:0] r;
    logic [7:0]  b;
    logic [15:0] h;
    r = w;
    b = w[8*off +: 8];
    h = off[1] ? w[31:16] : w[15:0];
    case (sz)
      SZ_BYTE: r = {{24{sgn & b[7]}}, b};
      SZ_HALF: r = {{16{sgn & h[15]}}, h};
      default: r = w;
    endcase
    return r;
  endfunction

  logic [7:0]  ctrl_q;
  logic        rsv_fault;
  assign rsv_fault = ctrl_q[`PBUS_CTRL_RSV_FAULT];

  // instruction unit state
  ifetch_state_t ist_q, ist_d;
  logic [29:0]   iaddr_q, iaddr_d;
  logic          ispace_q, ispace_d;
  logic          ipend_q, ipend_d;
  logic          ivalid_q, ivalid_d;
  logic [31:0]   iword_q, iword_d;
  logic          ifault_q, ifault_d;
  reply_kind_t   ikind;
  logic          ihold;
  logic          iuse;
  logic          ifault_now;
  logic          ievent;

  assign ikind      = reply_kind(instr_side_reply_i, rsv_fault);
  assign ihold      = ipend_q && (ikind == RK_WAIT);
  assign iuse       = ipend_q && !ihold;
  assign ifault_now = iuse && (ikind == RK_FAULT);
  assign ievent     = exc_taken_i || rte_invalid_i;

  // next phase of the instruction bus; later branches lose to earlier ones
  always_comb
  begin
    ist_d    = ist_q;
    iaddr_d  = iaddr_q;
    ispace_d = ispace_q;
    ipend_d  = ipend_q;
    ivalid_d = iuse;
    iword_d  = iuse ? instr_word_lines_i : iword_q;
    ifault_d = ifault_now;
    if (ievent)
    begin
      ist_d    = IST_NULL;
      iaddr_d  = target_i;
      ispace_d = supervisor_i;
      ipend_d  = 1'b0;
    end
    else if (redirect_i)
    begin
      ist_d    = IST_FETCH;
      iaddr_d  = target_i;
      ispace_d = supervisor_i;
      ipend_d  = 1'b0;
    end
    else if (ihold)
    begin
      ipend_d = 1'b1; // bus phase repeats untouched
    end
    else if (ifault_now)
    begin
      ist_d   = IST_FETCH; // access after the fault is dropped and repeated
      ipend_d = 1'b0;
    end
    else
    begin
      case (ist_q)
        IST_FETCH:
        begin
          ipend_d = !stall_i;
          if (!stall_i)
          begin
            iaddr_d  = iaddr_q + 30'h1;
            ispace_d = supervisor_i;
          end
        end
        IST_BOOT, IST_NULL:
        begin
          ist_d   = IST_FETCH;
          ipend_d = 1'b0;
        end
        default:
        begin
          ist_d   = IST_BOOT;
          ipend_d = 1'b0;
        end
      endcase
    end
  end

  // instruction registers, reset lands on the single boot null
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ist_q    <= IST_BOOT;
      iaddr_q  <= `PBUS_RESET_VECTOR;
      ispace_q <= 1'b1;
      ipend_q  <= 1'b0;
      ivalid_q <= 1'b0;
      iword_q  <= 32'h00000000;
      ifault_q <= 1'b0;
    end
    else
    begin
      ist_q    <= ist_d;
      iaddr_q  <= iaddr_d;
      ispace_q <= ispace_d;
      ipend_q  <= ipend_d;
      ivalid_q <= ivalid_d;
      iword_q  <= iword_d;
      ifault_q <= ifault_d;
    end
  end

  // strobe is floated only during the boot null
  assign instr_word_address_o    = iaddr_q;
  assign instr_space_select_o    = ispace_q;
  assign instr_fetch_strobe_o    = (ist_q == IST_FETCH);
  assign instr_fetch_strobe_oe_o = (ist_q != IST_BOOT);
  assign instr_valid_o           = ivalid_q;
  assign instr_word_o            = iword_q;
  assign instr_fault_o           = ifault_q;

  // data unit: bus phase registers and the metadata of the pending reply
  logic [29:0]  daddr_q, daddr_d;
  logic         dspace_q, dspace_d;
  logic [3:0]   dbe_q, dbe_d;
  logic         drnw_q, drnw_d;
  logic         data_bus_lock_q, data_bus_lock_d;
  logic [31:0]  dwdata_q, dwdata_d;
  logic [1:0]   doff_q, doff_d;
  access_size_t dsize_q, dsize_d;
  logic         dsgn_q, dsgn_d;
  logic         dpend_q, dpend_d;
  logic [1:0]   poff_q, poff_d;
  access_size_t psize_q, psize_d;
  logic         psgn_q, psgn_d;
  logic         prd_q, prd_d;
  logic         dvalid_q, dvalid_d;
  logic [31:0]  ddata_q, ddata_d;
  logic         dfault_q, dfault_d;
  reply_kind_t  dkind;
  logic         dhold;
  logic         daccept;

  assign dkind        = reply_kind(data_side_reply_i, rsv_fault);
  assign dhold        = dpend_q && (dkind == RK_WAIT);
  assign dreq_ready_o = !dhold; // one request per cycle unless a wait holds the bus
  assign daccept      = dreq_valid_i && !dhold;

  // accepted request becomes next phase; otherwise a null phase follows, unless a wait holds the phase
  always_comb
  begin
    daddr_d  = daddr_q;
    dspace_d = dspace_q;
    dbe_d    = dbe_q;
    drnw_d   = drnw_q;
    data_bus_lock_d  = data_bus_lock_q;
    dwdata_d = dwdata_q;
    doff_d   = doff_q;
    dsize_d  = dsize_q;
    dsgn_d   = dsgn_q;
    dpend_d  = dpend_q;
    poff_d   = poff_q;
    psize_d  = psize_q;
    psgn_d   = psgn_q;
    prd_d    = prd_q;
    dvalid_d = dpend_q && !dhold;
    ddata_d  = ddata_q;
    dfault_d = dpend_q && !dhold && (dkind == RK_FAULT);
    if (dpend_q && !dhold && prd_q)
    begin
      ddata_d = extract(data_word_lines_i, poff_q, psize_q, psgn_q);
    end
    if (!dhold)
    begin
      dpend_d = (dbe_q != 4'h0);
      poff_d  = doff_q;
      psize_d = dsize_q;
      psgn_d  = dsgn_q;
      prd_d   = drnw_q;
      data_bus_lock_d = data_bus_lock_i;
      dbe_d   = 4'h0;    // null keeps address and data lines
      if (daccept)
      begin
        daddr_d  = dreq_addr_i[31:2];
        dspace_d = supervisor_i;
        dbe_d    = lane_mask(dreq_size_i, dreq_addr_i[1:0]);
        drnw_d   = !dreq_write_i;
        dwdata_d = dreq_write_i ? spread(dreq_size_i, dreq_wdata_i) : dwdata_q;
        doff_d   = dreq_addr_i[1:0];
        dsize_d  = dreq_size_i;
        dsgn_d   = dreq_signed_i;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      daddr_q  <= 30'h00000000;
      dspace_q <= 1'b1;
      dbe_q    <= 4'h0;
      drnw_q   <= 1'b1;
      data_bus_lock_q  <= 1'b0;
      dwdata_q <= 32'h00000000;
      doff_q   <= 2'h0;
      dsize_q  <= SZ_WORD;
      dsgn_q   <= 1'b0;
      dpend_q  <= 1'b0;
      poff_q   <= 2'h0;
      psize_q  <= SZ_WORD;
      psgn_q   <= 1'b0;
      prd_q    <= 1'b1;
      dvalid_q <= 1'b0;
      ddata_q  <= 32'h00000000;
      dfault_q <= 1'b0;
    end
    else
    begin
      daddr_q  <= daddr_d;
      dspace_q <= dspace_d;
      dbe_q    <= dbe_d;
      drnw_q   <= drnw_d;
      data_bus_lock_q  <= data_bus_lock_d;
      dwdata_q <= dwdata_d;
      doff_q   <= doff_d;
      dsize_q  <= dsize_d;
      dsgn_q   <= dsgn_d;
      dpend_q  <= dpend_d;
      poff_q   <= poff_d;
      psize_q  <= psize_d;
      psgn_q   <= psgn_d;
      prd_q    <= prd_d;
      dvalid_q <= dvalid_d;
      ddata_q  <= ddata_d;
      dfault_q <= dfault_d;
    end
  end

  // data lines released only for an active read phase
  assign data_word_address_o   = daddr_q;
  assign data_space_select_o   = dspace_q;
  assign byte_lane_enables_o   = dbe_q;
  assign data_read_not_write_o = drnw_q;
  assign data_bus_lock_o       = data_bus_lock_q;
  assign data_word_lines_o     = dwdata_q;
  assign data_word_lines_oe_o  = !((dbe_q != 4'h0) && drnw_q);
  assign drsp_valid_o          = dvalid_q;
  assign drsp_data_o           = ddata_q;
  assign drsp_fault_o          = dfault_q;

  // register file: control, sticky reserved-reply flags (instruction flag only while reserved maps to fault), fault counters
  logic [7:0]  ctrl_d;
  logic [1:0]  stat_q, stat_d;
  logic [15:0] icnt_q, icnt_d;
  logic [15:0] dcnt_q, dcnt_d;
  logic        ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic        wb_req;
  logic        hit;
  logic        irsv_seen;
  logic        drsv_seen;
  logic        dfault_now;

  assign wb_req     = wb_cyc_i && wb_stb_i && !ack_q;
  assign hit        = (wb_adr_i[WB_ADDR_W-1:4] == '0);
  assign irsv_seen  = iuse && (instr_side_reply_i == `PBUS_REPLY_RSVD);
  assign drsv_seen  = dpend_q && (data_side_reply_i == `PBUS_REPLY_RSVD);
  assign dfault_now = dpend_q && !dhold && (dkind == RK_FAULT);

  // hardware set wins over a software clear in the same cycle
  always_comb
  begin
    ctrl_d = ctrl_q;
    stat_d = stat_q;
    icnt_d = icnt_q;
    dcnt_d = dcnt_q;
    ack_d  = wb_req;
    rdat_d = 32'h00000000;
    if (wb_req && hit && wb_we_i)
    begin
      case (wb_adr_i[3:0])
        `PBUS_REG_CTRL:   ctrl_d = wb_sel_i[0] ? wb_dat_i[7:0] : ctrl_q;
        `PBUS_REG_STATUS: stat_d = wb_sel_i[0] ? (stat_q & ~wb_dat_i[1:0]) : stat_q;
        `PBUS_REG_FAULTS:
        begin
          icnt_d = 16'h0000;
          dcnt_d = 16'h0000;
        end
        default: ctrl_d = ctrl_q;
      endcase
    end
    if (wb_req && hit && !wb_we_i)
    begin
      case (wb_adr_i[3:0])
        `PBUS_REG_CTRL:   rdat_d = {24'h000000, ctrl_q};
        `PBUS_REG_STATUS: rdat_d = {30'h00000000, stat_q};
        `PBUS_REG_FAULTS: rdat_d = {dcnt_q, icnt_q};
        default:          rdat_d = 32'h00000000;
      endcase
    end
    if (irsv_seen)
    begin
      stat_d[`PBUS_STAT_IRSV] = 1'b1;
    end
    if (drsv_seen)
    begin
      stat_d[`PBUS_STAT_DRSV] = 1'b1;
    end
    // counters saturate so a fault storm cannot wrap to zero
    if (ifault_now && (icnt_d != 16'hffff))
    begin
      icnt_d = icnt_d + 16'h1;
    end
    if (dfault_now && (dcnt_d != 16'hffff))
    begin
      dcnt_d = dcnt_d + 16'h1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= `PBUS_CTRL_RESET;
      stat_q <= `PBUS_STAT_RESET;
      icnt_q <= 16'h0000;
      dcnt_q <= 16'h0000;
      ack_q  <= 1'b0;
      rdat_q <= 32'h00000000;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      stat_q <= stat_d;
      icnt_q <= icnt_d;
      dcnt_q <= dcnt_d;
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // checks on the bus behaviour
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_reply_dropped;
    ##1 !instr_valid_o;
  endsequence

  sequence s_one_null_then_fetch;
    (!instr_fetch_strobe_o && !instr_fetch_strobe_oe_o) ##1 (instr_fetch_strobe_o && instr_fetch_strobe_oe_o);
  endsequence

  boot_null_a: assert property ($fell(rst_i) |-> s_one_null_then_fetch)
    else $error("boot null missing or not single");
  wait_repeat_a: assert property ((ihold && !ievent && !redirect_i) |=> ($stable(instr_word_address_o)
    && $stable(instr_space_select_o) && $stable(instr_fetch_strobe_o) && !instr_valid_o))
    else $error("wait reply did not hold the instruction phase");
  stall_repeat_a: assert property ((instr_fetch_strobe_o && stall_i && !ihold && !ievent && !redirect_i
    && !ifault_now) |=> $stable(instr_word_address_o) ##0 s_reply_dropped)
    else $error("stall repeat changed address or used reply");
  fault_mark_a: assert property ((ifault_now && !ievent && !redirect_i) |=> (instr_valid_o && instr_fault_o
    && $stable(instr_word_address_o)) ##0 s_reply_dropped)
    else $error("fault reply not marked or follower not dropped");
  event_null_a: assert property (ievent |=> (!instr_fetch_strobe_o && instr_fetch_strobe_oe_o
    && instr_word_address_o == $past(target_i)))
    else $error("null instruction phase not issued");
  fetch_always_a: assert property ((!$past(ievent) && !$past(rst_i)) |-> instr_fetch_strobe_o)
    else $error("strobe negated outside the null cases");
  null_ignore_a: assert property ((byte_lane_enables_o == 4'h0 && !dhold) |=> ##1 !drsp_valid_o)
    else $error("reply to data null phase was used");
  read_dir_a: assert property ((daccept && !dreq_write_i) |=> (data_read_not_write_o && !data_word_lines_oe_o
    && byte_lane_enables_o != 4'h0))
    else $error("read phase direction or release wrong");
  byte_write_a: assert property ((daccept && dreq_write_i && dreq_size_i == SZ_BYTE) |=>
    ($onehot(byte_lane_enables_o) && data_word_lines_o == {4{$past(dreq_wdata_i[7:0])}}
    && data_word_lines_oe_o && !data_read_not_write_o))
    else $error("byte write lanes wrong");
  back_to_back_a: assert property ((daccept ##1 daccept) |=> (byte_lane_enables_o != 4'h0) ##1
    (drsp_valid_o || dhold || $past(dhold)))
    else $error("pipelined data phases not issued each cycle");
  data_hold_a: assert property (dhold |=> ($stable(data_word_address_o) && $stable(byte_lane_enables_o)
    && $stable(data_word_lines_o) && !drsp_valid_o))
    else $error("data wait did not hold the phase");
endmodule

// ==== tb/bus_slave_model.sv ====
`timescale 1ns/10ps
module bus_slave_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        iwait_i,
  input  wire logic        ifault_i,
  input  wire logic [29:0] iadr_i,
  input  wire logic        ifetch_i,
  input  wire logic        ifetch_oe_i,
  output logic      [31:0] iword_o,
  output logic      [1:0]  irep_o,
  input  wire logic [29:0] dadr_i,
  input  wire logic [3:0]  dbe_i,
  input  wire logic        drnw_i,
  input  wire logic [31:0] dwr_i,
  input  wire logic        dwait_i,
  output logic      [31:0] drd_o,
  output logic      [1:0]  drep_o
);
  logic        iph_q;
  logic        dph_q;
  logic        drnw_q;
  logic [29:0] iadr_q;
  logic [3:0]  didx_q;
  logic [31:0] mem_q [16];
  // both buses sampled every edge; a wait keeps the old phase
  always_ff @(posedge clk_i)
  begin
    if (rst_i || irep_o != 2'h1)
    begin
      iph_q  <= ifetch_i & ifetch_oe_i & !rst_i;
      iadr_q <= iadr_i;
    end
    if (rst_i || drep_o != 2'h1)
    begin
      dph_q  <= (dbe_i != 4'h0) & !rst_i;
      drnw_q <= drnw_i;
      didx_q <= dadr_i[3:0];
    end
    for (int b = 0; b < 4; b++)
      if (dbe_i[b] && !drnw_i && !rst_i)
        mem_q[dadr_i[3:0]][8*b+:8] <= dwr_i[8*b+:8]; // lane b
  end
  // whole word on reads; released lines show the inverse, not a stale copy
  assign iword_o = iph_q ? {iadr_q, 2'h1} : ~{iadr_q, 2'h1};
  assign drd_o   = (dph_q && drnw_q) ? mem_q[didx_q] : ~mem_q[didx_q];
  // unanswered reply lines float to 11 like a pull-up
  assign irep_o = !iph_q ? 2'h3 : iwait_i ? 2'h1 : ifault_i ? 2'h3 : 2'h2;
  assign drep_o = !dph_q ? 2'h3 : dwait_i ? 2'h1 : 2'h2;
endmodule

// ==== tb/pipelined_processor_bus_port_test.sv ====
`timescale 1ns/10ps
module pipelined_processor_bus_port_test;
  import pbus_pkg::*;
  logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, supervisor_i = 1;
  logic        stall_i = 0, redirect_i = 0, rte_invalid_i = 0, exc_taken_i = 0, dreq_valid_i = 0;
  logic        dreq_write_i = 0, dreq_signed_i = 0, data_bus_lock_i = 0, iwait = 0, ifault = 0, dwait = 0;
  logic [7:0]  wb_adr_i = 0;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 0, dreq_addr_i = 0, dreq_wdata_i = 0;
  logic [29:0] target_i = 0;
  access_size_t dreq_size_i = SZ_WORD;
  logic [31:0] wb_dat_o, instr_word_o, drsp_data_o, instr_word_lines_i, data_word_lines_o, data_word_lines_i;
  logic [29:0] instr_word_address_o, data_word_address_o;
  logic [3:0]  byte_lane_enables_o;
  logic [1:0]  instr_side_reply_i, data_side_reply_i;
  logic        wb_ack_o, instr_valid_o, instr_fault_o, dreq_ready_o, drsp_valid_o, drsp_fault_o;
  logic        instr_space_select_o, instr_fetch_strobe_o, instr_fetch_strobe_oe_o, data_space_select_o;
  logic        data_read_not_write_o, data_bus_lock_o, data_word_lines_oe_o;
  int          err_total = 0;
  int          cmp_count = 0;

  pipelined_processor_bus_port pipelined_processor_bus_port_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .supervisor_i, .stall_i, .redirect_i,
    .rte_invalid_i, .exc_taken_i, .target_i, .instr_valid_o, .instr_word_o, .instr_fault_o, .dreq_valid_i,
    .dreq_ready_o, .dreq_write_i, .dreq_signed_i, .dreq_size_i, .dreq_addr_i, .dreq_wdata_i, .data_bus_lock_i,
    .drsp_valid_o, .drsp_data_o, .drsp_fault_o, .instr_word_address_o, .instr_space_select_o,
    .instr_fetch_strobe_o, .instr_fetch_strobe_oe_o, .instr_word_lines_i, .instr_side_reply_i,
    .data_word_address_o, .data_space_select_o, .byte_lane_enables_o, .data_read_not_write_o,
    .data_bus_lock_o, .data_word_lines_o, .data_word_lines_oe_o, .data_word_lines_i, .data_side_reply_i);
  bus_slave_model bus_slave_model_inst (.clk_i, .rst_i, .iwait_i(iwait), .ifault_i(ifault), .dwait_i(dwait),
    .iadr_i(instr_word_address_o), .ifetch_i(instr_fetch_strobe_o), .ifetch_oe_i(instr_fetch_strobe_oe_o),
    .iword_o(instr_word_lines_i), .irep_o(instr_side_reply_i), .dadr_i(data_word_address_o),
    .dbe_i(byte_lane_enables_o), .drnw_i(data_read_not_write_o), .dwr_i(data_word_lines_o),
    .drd_o(data_word_lines_i), .drep_o(data_side_reply_i));

  always #2.5 clk_i = ~clk_i;

  task automatic give_verdict();
    if (err_total == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // outputs are read at the edge, before that edge's updates land
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_sel_i <= 4'hf;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic t_boot();
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(instr_fetch_strobe_oe_o, 0);
    for (int k = 0; k < 5; k++)
    begin
      @(posedge clk_i);
      chk({instr_fetch_strobe_o, instr_fetch_strobe_oe_o, instr_word_address_o}, {2'b11, 30'(k)});
      chk(instr_valid_o, k > 1);
      if (k > 1)
        chk(instr_word_o, {30'(k - 2), 2'h1});
    end
  endtask

  task automatic t_wait();
    logic [29:0] a;
    repeat (3) @(posedge clk_i);
    a = instr_word_address_o;
    iwait <= 1'b1;
    @(posedge clk_i);
    iwait <= 1'b0;
    @(posedge clk_i);
    chk({instr_valid_o, instr_word_address_o}, {1'b0, a + 30'h1});
    @(posedge clk_i);
    chk({instr_valid_o, instr_word_o}, {1'b1, a, 2'h1});
  endtask

  // space select flips as the stall starts and must not leak into the repeats
  task automatic t_stall();
    logic [29:0] a;
    repeat (3) @(posedge clk_i);
    a = instr_word_address_o;
    stall_i <= 1'b1;
    supervisor_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({instr_space_select_o, instr_word_address_o}, {1'b1, a + 30'h1});
    @(posedge clk_i);
    chk({instr_valid_o, instr_space_select_o, instr_word_address_o}, {2'b01, a + 30'h1});
    stall_i <= 1'b0;
    supervisor_i <= 1'b1;
    @(posedge clk_i);
    chk(instr_valid_o, 0);
  endtask

  task automatic t_evt(input int kind, input logic [29:0] t);
    @(posedge clk_i);
    target_i <= t;
    redirect_i <= (kind == 0);
    rte_invalid_i <= (kind == 1);
    exc_taken_i <= (kind == 2);
    @(posedge clk_i);
    {redirect_i, rte_invalid_i, exc_taken_i} <= 3'h0;
    @(posedge clk_i);
    chk({instr_fetch_strobe_o, instr_word_address_o}, {kind == 0, t});
    @(posedge clk_i);
    chk({instr_fetch_strobe_o, instr_word_address_o}, {1'b1, t + 30'(kind == 0)});
  endtask

  task automatic t_fault();
    repeat (3) @(posedge clk_i);
    ifault <= 1'b1;
    @(posedge clk_i);
    ifault <= 1'b0;
    @(posedge clk_i);
    chk({instr_valid_o, instr_fault_o}, 2'b11);
    t_evt(2, 30'h40);
  endtask

  // writes are locked and user space, reads unlocked and supervisor
  task automatic t_data(input logic wr, sg, input access_size_t sz, input logic [31:0] adr, wd,
                        input logic [3:0] be, input logic [31:0] exp);
    repeat (3) @(posedge clk_i);
    dreq_valid_i <= 1'b1;
    dreq_write_i <= wr;
    dreq_signed_i <= sg;
    dreq_size_i <= sz;
    dreq_addr_i <= adr;
    dreq_wdata_i <= wd;
    data_bus_lock_i <= wr;
    supervisor_i <= !wr;
    @(posedge clk_i);
    chk(dreq_ready_o, 1);
    dreq_valid_i <= 1'b0;
    @(posedge clk_i);
    chk({data_space_select_o, data_bus_lock_o, data_read_not_write_o, data_word_lines_oe_o, byte_lane_enables_o,
         data_word_address_o}, {!wr, wr, !wr, wr, be, adr[31:2]});
    if (wr)
      chk(data_word_lines_o, exp);
    @(posedge clk_i);
    chk({drsp_valid_o, byte_lane_enables_o}, 0);
    @(posedge clk_i);
    chk({drsp_valid_o, drsp_fault_o}, 2'b10);
    if (!wr)
      chk(drsp_data_o, exp);
  endtask

  // data wait stalls the port, holds phase two
  task automatic t_dwait();
    repeat (3) @(posedge clk_i);
    dreq_valid_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    dwait <= 1'b1;
    @(posedge clk_i);
    chk(dreq_ready_o, 0);
    {dwait, dreq_valid_i} <= 2'h0;
    @(posedge clk_i);
    chk({drsp_valid_o, byte_lane_enables_o}, 5'h0f);
    repeat (2)
    begin
      @(posedge clk_i);
      chk({drsp_valid_o, drsp_data_o}, {1'b1, 32'hcafe0001});
    end
  endtask

  task automatic t_regs();
    logic [31:0] rd;
    wb(1'b0, 8'h00, 32'h0, rd);
    chk(rd, 0);
    wb(1'b1, 8'h00, 32'h1, rd);
    wb(1'b0, 8'h00, 32'h0, rd);
    chk(rd, 1);
    wb(1'b0, 8'h40, 32'h0, rd);
    chk(rd, 0);
    wb(1'b0, 8'h08, 32'h0, rd);
    chk(rd, 32'h1);
    wb(1'b1, 8'h00, 32'h0, rd);
  endtask

  initial
  begin
    t_boot();
    t_wait();
    t_stall();
    t_fault();
    t_evt(0, 30'h100);
    t_evt(1, 30'h200);
    t_data(1'b1, 1'b0, SZ_BYTE, 32'h105, 32'h85, 4'h2, 32'h85858585);
    t_data(1'b0, 1'b1, SZ_BYTE, 32'h105, 32'h0, 4'h2, 32'hffffff85);
    t_data(1'b1, 1'b0, SZ_HALF, 32'h10a, 32'h1234, 4'hc, 32'h12341234);
    t_data(1'b0, 1'b0, SZ_HALF, 32'h10a, 32'h0, 4'hc, 32'h1234);
    t_data(1'b1, 1'b0, SZ_WORD, 32'h10c, 32'hcafe0001, 4'hf, 32'hcafe0001);
    t_data(1'b0, 1'b0, SZ_WORD, 32'h10c, 32'h0, 4'hf, 32'hcafe0001);
    t_dwait();
    t_regs();
    give_verdict();
  end

  // cut a hang well past the expected run length
  initial
  begin
    #20000;
    err_total++;
    give_verdict();
  end
endmodule
